// ===== hw/ahl_lookup.v
// Function
// - extended mode makes each translation record 16 bytes instead of 8
// - extended records hold two 32-bit counters after the first eight bytes
// - first counter counts every cell finally routed by the record
// - second counter counts routed cells whose PTI and CLP match control values
// - above 16 ports, even and odd port pairs share one table region
// - up to 16 ports, OAM base is port times 16 times 64
// - above 16 ports, OAM base is port/2 truncated times 16 times 64
// - F4 OAM record address is OAM base plus VCI times 16
// - VCI six with PTI 110 uses OAM base plus 200h instead
// - F5 records at OAM base plus 210h..240h for PTI 100..111
// - VPI record address is selected VPI bits times 16 plus stored base
// - VCI record address is VCI*16 plus VCI offset plus 100000h
// - misrouted when A,I are 00, VCI out of range, or unused VPI bits set
// - misrouted cells raise the matching enabled event
// - capture registers hold the first four header bytes, high and low
// - capture only from selected ports, first cell after capture-clear set
// - port indicator field records the captured cell's port
// - port with lookup disabled has its configuration bits ignored
// - PHY mode uses only port 0 table entries
// - 16 to 32 ports in extended mode give a 16 Kbyte OAM area
// - F4 OAM record read only when E set and VCI below 32
// - VPI out of range cell is discarded and not counted
`include "ahl_regs.vh"

module ahl_lookup (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata_ff,
    output reg reg_rvalid_ff,
    input wire cell_valid,
    input wire [4:0] cell_port,
    input wire [31:0] cell_hdr,
    output reg cell_ready_ff,
    output reg done_ff,
    output reg discard_ff,
    output reg misrouted_ff,
    output reg evt_mis_cell_ff,
    output reg evt_vci_or_ff,
    output reg evt_vpi_or_ff,
    output reg [20:0] sram_addr_ff,
    output reg sram_rd_ff,
    output reg sram_wr_ff,
    output reg [31:0] sram_wdata_ff,
    input wire [31:0] sram_rdata
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_BASE = 4'h1;
    localparam [3:0] S_VPI = 4'h2;
    localparam [3:0] S_VMAX = 4'h3;
    localparam [3:0] S_OAM = 4'h4;
    localparam [3:0] S_VCI = 4'h5;
    localparam [3:0] S_F5 = 4'h6;
    localparam [3:0] S_CNT = 4'h7;
    localparam [3:0] S_C0 = 4'h8;
    localparam [3:0] S_C1R = 4'h9;
    localparam [3:0] S_C1 = 4'hA;
    localparam [3:0] S_END = 4'hB;

    // misroute kinds
    localparam [1:0] M_NONE = 2'h0;
    localparam [1:0] M_CELL = 2'h1;
    localparam [1:0] M_VCI = 2'h2;
    localparam [1:0] M_VPI = 2'h3;

    reg [15:0] ext_cfg_ff;
    reg [15:0] ext_ctl_ff;
    reg [15:0] mis_sel_ff;
    reg mis_arm_ff;
    reg mis_latch_ff;
    reg [4:0] mis_port_ff;
    reg [15:0] mis_hi_ff;
    reg [15:0] mis_lo_ff;
    reg rd_pend_ff;
    reg [15:0] rd_addr_ff;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [31:0] hdr_ff;
    reg [4:0] port_ff;
    reg [15:0] pcfg_ff;
    reg [15:0] pbase_ff;
    reg [31:0] vpi_w0_ff;
    reg [20:0] rec_ff;
    reg [20:0] nxt_rec;
    reg [1:0] mis_ff;
    reg [1:0] nxt_mis;
    reg rd_dly_ff;
    reg [20:0] nxt_addr;
    reg nxt_rd;
    reg nxt_wr;
    reg [31:0] nxt_wdata;

    wire ext = ext_cfg_ff[`AHL_CFG_EXT_BIT];
    wire many = ext_cfg_ff[`AHL_CFG_MANY_BIT];
    wire phy = ext_cfg_ff[`AHL_CFG_PHY_BIT];

    function in_range;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi) && !a[0];
        end
    endfunction

    // record index to byte offset, 16 or 8 bytes per record
    function [20:0] rec_off;
        input [15:0] idx;
        input ext_mode;
        begin
            if (ext_mode)
                rec_off = {1'b0, idx, 4'h0};
            else
                rec_off = {2'b00, idx, 3'h0};
        end
    endfunction

    function rec_valid;
        input [31:0] w;
        begin
            rec_valid = w[`AHL_REC_A_BIT] && !w[`AHL_REC_I_BIT];
        end
    endfunction

    function rec_null;
        input [31:0] w;
        begin
            rec_null = !w[`AHL_REC_A_BIT] && !w[`AHL_REC_I_BIT];
        end
    endfunction

    function oam_routes;
        input [31:0] w;
        begin
            oam_routes = rec_valid(w) && !(!w[`AHL_REC_C1_BIT] && w[`AHL_REC_C0_BIT]);
        end
    endfunction

    // register port decode
    wire [15:0] pcfg_diff = reg_addr - `AHL_PCFG_FIRST;
    wire wr_pcfg = reg_wr && in_range(reg_addr, `AHL_PCFG_FIRST, `AHL_PCFG_LAST);
    wire wr_pbase = reg_wr && in_range(reg_addr, `AHL_PBASE_FIRST, `AHL_PBASE_LAST);
    wire [4:0] mem_waddr = wr_pcfg ? pcfg_diff[5:1] : reg_addr[5:1];
    wire [15:0] rd_diff = rd_addr_ff - `AHL_PCFG_FIRST;
    wire [4:0] cpu_raddr = reg_rd ? (in_range(reg_addr, `AHL_PCFG_FIRST, `AHL_PCFG_LAST) ?
                                     pcfg_diff[5:1] : reg_addr[5:1]) : rd_diff[5:1];

    // port seen by the table
    wire [4:0] eport = phy ? 5'h00 : cell_port;
    wire [4:0] tport = (many && ext) ? {1'b0, port_ff[4:1]} : port_ff;
    wire [4:0] lk_port = (many && ext) ? {1'b0, eport[4:1]} : eport;
    wire [31:0] lk_word;
    wire [31:0] cpu_word;

    ahl_port_mem u_mem (
        .clk(clk),
        .ce(ce),
        .we_lo(wr_pcfg),
        .we_hi(wr_pbase),
        .waddr(mem_waddr),
        .wdata(reg_wdata),
        .raddr_a(lk_port),
        .rdata_a_ff(lk_word),
        .raddr_b(cpu_raddr),
        .rdata_b_ff(cpu_word)
    );

    // header fields
    wire [11:0] vpi = hdr_ff[31:20];
    wire [15:0] vci = hdr_ff[19:4];
    wire [2:0] pti = hdr_ff[3:1];
    wire clp = hdr_ff[0];

    // disabled port: its config bits read as zero
    wire [15:0] cfg_eff = lk_word[`AHL_PCFG_EN_BIT] ? lk_word[15:0] : 16'h0000;
    wire [15:0] pcfg_now = (state_ff == S_BASE) ? cfg_eff : pcfg_ff;
    wire [15:0] pbase_now = (state_ff == S_BASE) ? lk_word[31:16] : pbase_ff;
    wire chk = pcfg_now[`AHL_PCFG_CHK_BIT];
    wire uni = pcfg_now[`AHL_PCFG_UNI_BIT];
    wire [1:0] vmask = pcfg_now[`AHL_PCFG_MASK_LSB+1:`AHL_PCFG_MASK_LSB];
    wire [11:0] ver_mask = uni ? 12'h0FF : 12'hFFF;

    reg [15:0] vpi_idx;
    reg [11:0] unused_bits;
    always @*
    begin
        case (vmask)
            2'b01:
            begin
                vpi_idx = {8'h00, vpi[7:0]};
                unused_bits = vpi & 12'hF00;
            end
            2'b10:
            begin
                vpi_idx = {12'h000, vpi[11:8]};
                unused_bits = vpi & 12'h0FF;
            end
            2'b11:
            begin
                vpi_idx = {4'h0, vpi};
                unused_bits = 12'h000;
            end
            default:
            begin
                vpi_idx = 16'h0000;
                unused_bits = vpi;
            end
        endcase
    end
    wire vpi_or = chk && ((unused_bits & ver_mask) != 12'h000);

    // addresses into the translation memory
    wire [20:0] oam_region_base = ext ? {6'h00, tport, 10'h000} : {7'h00, tport, 9'h000};
    wire [20:0] vpi_addr = {2'b00, pbase_now, 3'h0} + rec_off(vpi_idx, ext);
    wire f4_special = (vci == `AHL_F4_SPECIAL_VCI) && (pti == `AHL_F4_SPECIAL_PTI);
    wire [20:0] f4_addr = oam_region_base + (f4_special ? (ext ? `AHL_F4_SPECIAL_EXT : `AHL_F4_SPECIAL_STD)
                                            : rec_off(vci, ext));
    wire [20:0] f5_addr = oam_region_base + (ext ? (`AHL_F5_BASE_EXT + {15'h0000, pti[1:0], 4'h0})
                                     : (`AHL_F5_BASE_STD + {16'h0000, pti[1:0], 3'h0}));
    wire [20:0] vci_addr = `AHL_VCI_START + rec_off(vci, ext)
                           + {2'b00, vpi_w0_ff[25:10], 3'h0};
    wire special = (pti == ext_ctl_ff[`AHL_CTL_PTI_LSB+2:`AHL_CTL_PTI_LSB])
                   && (clp == ext_ctl_ff[`AHL_CTL_CLP_BIT]);

    // lookup sequencer
    always @*
    begin
        nxt_state = state_ff;
        nxt_rec = rec_ff;
        nxt_mis = mis_ff;
        nxt_addr = sram_addr_ff;
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        nxt_wdata = sram_wdata_ff;
        case (state_ff)
            S_IDLE:
            begin
                if (cell_valid && cell_ready_ff)
                begin
                    nxt_mis = M_NONE;
                    nxt_state = S_BASE;
                end
            end
            S_BASE:
            begin
                if (vpi_or)
                begin
                    nxt_mis = M_VPI;
                    nxt_state = S_END;
                end
                else
                begin
                    nxt_rd = 1'b1;
                    nxt_addr = vpi_addr;
                    nxt_state = S_VPI;
                end
            end
            S_VPI:
            begin
                if (rd_dly_ff)
                begin
                    if (rec_null(sram_rdata))
                    begin
                        nxt_mis = M_CELL;
                        nxt_state = S_END;
                    end
                    else if (!rec_valid(sram_rdata))
                        nxt_state = S_END;
                    else if (sram_rdata[`AHL_REC_E_BIT] && (vci < `AHL_F4_VCI_LIMIT))
                    begin
                        nxt_rd = 1'b1;
                        nxt_addr = f4_addr;
                        nxt_state = S_OAM;
                    end
                    else if (sram_rdata[`AHL_REC_P_BIT])
                    begin
                        nxt_rec = sram_addr_ff;
                        nxt_state = S_CNT;
                    end
                    else
                    begin
                        nxt_rd = 1'b1;
                        nxt_addr = sram_addr_ff + 21'h00_0004;
                        nxt_state = S_VMAX;
                    end
                end
            end
            S_OAM:
            begin
                if (rd_dly_ff)
                begin
                    if (oam_routes(sram_rdata))
                    begin
                        nxt_rec = sram_addr_ff;
                        nxt_state = S_CNT;
                    end
                    else if (vpi_w0_ff[`AHL_REC_P_BIT])
                    begin
                        nxt_rec = vpi_addr;
                        nxt_state = S_CNT;
                    end
                    else
                    begin
                        nxt_rd = 1'b1;
                        nxt_addr = vpi_addr + 21'h00_0004;
                        nxt_state = S_VMAX;
                    end
                end
            end
            S_VMAX:
            begin
                if (rd_dly_ff)
                begin
                    if (vci > sram_rdata[15:0])
                    begin
                        nxt_mis = M_VCI;
                        nxt_state = S_END;
                    end
                    else
                    begin
                        nxt_rd = 1'b1;
                        nxt_addr = vci_addr;
                        nxt_state = S_VCI;
                    end
                end
            end
            S_VCI:
            begin
                if (rd_dly_ff)
                begin
                    if (rec_null(sram_rdata))
                    begin
                        nxt_mis = M_CELL;
                        nxt_state = S_END;
                    end
                    else if (!rec_valid(sram_rdata))
                        nxt_state = S_END;
                    else if (sram_rdata[`AHL_REC_E_BIT] && pti[2])
                    begin
                        nxt_rd = 1'b1;
                        nxt_addr = f5_addr;
                        nxt_rec = sram_addr_ff;
                        nxt_state = S_F5;
                    end
                    else
                    begin
                        nxt_rec = sram_addr_ff;
                        nxt_state = S_CNT;
                    end
                end
            end
            S_F5:
            begin
                if (rd_dly_ff)
                begin
                    if (oam_routes(sram_rdata))
                        nxt_rec = sram_addr_ff;
                    nxt_state = S_CNT;
                end
            end
            S_CNT:
            begin
                if (ext)
                begin
                    nxt_rd = 1'b1;
                    nxt_addr = rec_ff + `AHL_CNT0_OFS;
                    nxt_state = S_C0;
                end
                else
                    nxt_state = S_END;
            end
            S_C0:
            begin
                if (rd_dly_ff)
                begin
                    nxt_wr = 1'b1;
                    nxt_wdata = sram_rdata + 32'h0000_0001;
                    nxt_state = special ? S_C1R : S_END;
                end
            end
            S_C1R:
            begin
                nxt_rd = 1'b1;
                nxt_addr = rec_ff + `AHL_CNT1_OFS;
                nxt_state = S_C1;
            end
            S_C1:
            begin
                if (rd_dly_ff)
                begin
                    nxt_wr = 1'b1;
                    nxt_wdata = sram_rdata + 32'h0000_0001;
                    nxt_state = S_END;
                end
            end
            S_END:
                nxt_state = S_IDLE;
            default:
                nxt_state = S_IDLE;
        endcase
    end

    wire at_end = (state_ff == S_END);
    wire mis_now = at_end && (mis_ff != M_NONE);
    wire cap_now = mis_now && mis_arm_ff && mis_sel_ff[tport[3:0]];
    wire clr_wr = reg_wr && (reg_addr == `AHL_MIS_CTL_ADDR) && reg_wdata[`AHL_MIS_CLR_BIT];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_ff <= S_IDLE;
            hdr_ff <= 32'h0000_0000;
            port_ff <= 5'h00;
            pcfg_ff <= `AHL_RST16;
            pbase_ff <= `AHL_RST16;
            vpi_w0_ff <= 32'h0000_0000;
            rec_ff <= 21'h00_0000;
            mis_ff <= M_NONE;
            rd_dly_ff <= 1'b0;
            sram_addr_ff <= 21'h00_0000;
            sram_rd_ff <= 1'b0;
            sram_wr_ff <= 1'b0;
            sram_wdata_ff <= 32'h0000_0000;
            cell_ready_ff <= 1'b0;
            done_ff <= 1'b0;
            discard_ff <= 1'b0;
            misrouted_ff <= 1'b0;
            evt_mis_cell_ff <= 1'b0;
            evt_vci_or_ff <= 1'b0;
            evt_vpi_or_ff <= 1'b0;
            ext_cfg_ff <= `AHL_RST16;
            ext_ctl_ff <= `AHL_RST16;
            mis_sel_ff <= `AHL_RST16;
            mis_arm_ff <= 1'b0;
            mis_latch_ff <= 1'b0;
            mis_port_ff <= 5'h00;
            mis_hi_ff <= `AHL_RST16;
            mis_lo_ff <= `AHL_RST16;
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= 16'h0000;
            reg_rdata_ff <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            rec_ff <= nxt_rec;
            mis_ff <= nxt_mis;
            sram_addr_ff <= nxt_addr;
            sram_rd_ff <= nxt_rd;
            sram_wr_ff <= nxt_wr;
            sram_wdata_ff <= nxt_wdata;
            rd_dly_ff <= sram_rd_ff;
            cell_ready_ff <= (nxt_state == S_IDLE);
            if (state_ff == S_IDLE && cell_valid && cell_ready_ff)
            begin
                hdr_ff <= cell_hdr;
                port_ff <= eport;
            end
            if (state_ff == S_BASE)
            begin
                pcfg_ff <= cfg_eff;
                pbase_ff <= lk_word[31:16];
            end
            if (state_ff == S_VPI && rd_dly_ff)
                vpi_w0_ff <= sram_rdata;
            // result and event pulses
            done_ff <= at_end;
            discard_ff <= at_end && (mis_ff != M_NONE);
            misrouted_ff <= mis_now;
            evt_mis_cell_ff <= mis_now && ext_ctl_ff[`AHL_CTL_IEN_MIS_BIT];
            evt_vci_or_ff <= mis_now && (mis_ff == M_VCI) && ext_ctl_ff[`AHL_CTL_IEN_VCI_BIT];
            evt_vpi_or_ff <= mis_now && (mis_ff == M_VPI) && ext_ctl_ff[`AHL_CTL_IEN_VPI_BIT];
            // capture of a misrouted header; capture beats a same-cycle re-arm
            if (cap_now)
            begin
                mis_hi_ff <= hdr_ff[31:16];
                mis_lo_ff <= hdr_ff[15:0];
                mis_port_ff <= port_ff;
                mis_arm_ff <= 1'b0;
                mis_latch_ff <= 1'b1;
            end
            else if (clr_wr)
            begin
                mis_arm_ff <= 1'b1;
                mis_latch_ff <= 1'b0;
            end
            if (reg_wr)
            begin
                case (reg_addr)
                    `AHL_EXT_CFG_ADDR: ext_cfg_ff <= reg_wdata;
                    `AHL_EXT_CTL_ADDR: ext_ctl_ff <= reg_wdata;
                    `AHL_MIS_SEL_ADDR: mis_sel_ff <= reg_wdata;
                    default: ;
                endcase
            end
            // reads answer two edges after the request
            rd_pend_ff <= reg_rd;
            if (reg_rd)
                rd_addr_ff <= reg_addr;
            reg_rvalid_ff <= rd_pend_ff;
            if (rd_pend_ff)
            begin
                if (in_range(rd_addr_ff, `AHL_PCFG_FIRST, `AHL_PCFG_LAST))
                    reg_rdata_ff <= cpu_word[15:0];
                else if (in_range(rd_addr_ff, `AHL_PBASE_FIRST, `AHL_PBASE_LAST))
                    reg_rdata_ff <= cpu_word[31:16];
                else
                begin
                    case (rd_addr_ff)
                        `AHL_EXT_CFG_ADDR: reg_rdata_ff <= ext_cfg_ff;
                        `AHL_EXT_CTL_ADDR: reg_rdata_ff <= ext_ctl_ff;
                        `AHL_MIS_SEL_ADDR: reg_rdata_ff <= mis_sel_ff;
                        `AHL_MIS_CTL_ADDR: reg_rdata_ff <= {1'b0, mis_latch_ff, 9'h000, mis_port_ff};
                        `AHL_MIS_HI_ADDR: reg_rdata_ff <= mis_hi_ff;
                        `AHL_MIS_LO_ADDR: reg_rdata_ff <= mis_lo_ff;
                        default: reg_rdata_ff <= 16'h0000;
                    endcase
                end
            end
        end
    end
endmodule // ahl_lookup

// ===== hw/ahl_port_mem.v
// per-port lookup config and base, two registered read ports
module ahl_port_mem (
    input wire clk,
    input wire ce,
    input wire we_lo,
    input wire we_hi,
    input wire [4:0] waddr,
    input wire [15:0] wdata,
    input wire [4:0] raddr_a,
    output reg [31:0] rdata_a_ff,
    input wire [4:0] raddr_b,
    output reg [31:0] rdata_b_ff
);
    reg [31:0] mem [0:31];

    always @(posedge clk)
    begin
        if (ce)
        begin
            if (we_lo)
                mem[waddr][15:0] <= wdata;
            if (we_hi)
                mem[waddr][31:16] <= wdata;
            rdata_a_ff <= mem[raddr_a];
            rdata_b_ff <= mem[raddr_b];
        end
    end
endmodule // ahl_port_mem

// ===== hw/ahl_regs.vh
`ifndef AHL_REGS_VH
`define AHL_REGS_VH

// register offsets (16-bit register port, byte addresses)
`define AHL_EXT_CFG_ADDR 16'h011E
`define AHL_EXT_CTL_ADDR 16'h0120
`define AHL_MIS_SEL_ADDR 16'h0142
`define AHL_MIS_CTL_ADDR 16'h0144
`define AHL_MIS_HI_ADDR 16'h0146
`define AHL_MIS_LO_ADDR 16'h0148
`define AHL_PCFG_FIRST 16'h0320
`define AHL_PCFG_LAST 16'h033E
`define AHL_PBASE_FIRST 16'h0380
`define AHL_PBASE_LAST 16'h03BE

// extended_lookup_config fields
`define AHL_CFG_EXT_BIT 0
`define AHL_CFG_MANY_BIT 1
`define AHL_CFG_PHY_BIT 2

// extended_lookup_control fields
`define AHL_CTL_CLP_BIT 0
`define AHL_CTL_PTI_LSB 1
`define AHL_CTL_IEN_MIS_BIT 4
`define AHL_CTL_IEN_VCI_BIT 5
`define AHL_CTL_IEN_VPI_BIT 6

// misroute_capture_control fields
`define AHL_MIS_CLR_BIT 15
`define AHL_MIS_LATCH_BIT 14

// port_lookup_config_status fields
`define AHL_PCFG_EN_BIT 0
`define AHL_PCFG_CHK_BIT 1
`define AHL_PCFG_MASK_LSB 2
`define AHL_PCFG_UNI_BIT 4

// reset values
`define AHL_RST16 16'h0000

// record word fields (word 0 of a record)
`define AHL_REC_A_BIT 31
`define AHL_REC_I_BIT 30
`define AHL_REC_E_BIT 29
`define AHL_REC_P_BIT 28
`define AHL_REC_C1_BIT 27
`define AHL_REC_C0_BIT 26

// translation memory layout
`define AHL_VCI_START 21'h10_0000
`define AHL_F4_SPECIAL_EXT 21'h00_0200
`define AHL_F4_SPECIAL_STD 21'h00_0100
`define AHL_F5_BASE_EXT 21'h00_0210
`define AHL_F5_BASE_STD 21'h00_0108
`define AHL_CNT0_OFS 21'h00_0008
`define AHL_CNT1_OFS 21'h00_000C
`define AHL_F4_VCI_LIMIT 16'h0020
`define AHL_F4_SPECIAL_VCI 16'h0006
`define AHL_F4_SPECIAL_PTI 3'h6

`endif

// ===== verif/ahl_lookup_assertions.sv
module ahl_lookup_assertions (
    input logic clk,
    input logic sys_rst,
    input logic ce,
    input logic reg_rd,
    input logic cell_valid,
    input logic cell_ready_ff,
    input logic done_ff,
    input logic discard_ff,
    input logic misrouted_ff,
    input logic evt_mis_cell_ff,
    input logic reg_rvalid_ff,
    input logic sram_wr_ff,
    input logic [20:0] sram_addr_ff,
    input logic [31:0] sram_wdata_ff,
    input logic [31:0] sram_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ready_drop_a: assert property (cell_valid && cell_ready_ff && ce |=> !cell_ready_ff)
        else $error("ready stayed high after taking a cell");
    read_latency_a: assert property (reg_rd && ce |-> ##2 reg_rvalid_ff)
        else $error("read answer late");
    done_pulse_a: assert property (done_ff |=> !done_ff)
        else $error("done longer than one cycle");
    done_ready_a: assert property (done_ff |-> cell_ready_ff)
        else $error("ready not back with done");
    discard_done_a: assert property (discard_ff |-> done_ff)
        else $error("discard without done");
    mis_event_a: assert property (evt_mis_cell_ff |-> misrouted_ff && done_ff)
        else $error("event without misrouted cell");
    rmw_data_a: assert property (sram_wr_ff |-> sram_wdata_ff == $past(sram_rdata) + 32'h0000_0001)
        else $error("counter write not old plus one");
    rmw_addr_a: assert property (sram_wr_ff |-> sram_addr_ff == $past(sram_addr_ff, 2))
        else $error("counter written elsewhere than read");
endmodule // ahl_lookup_assertions

bind ahl_lookup ahl_lookup_assertions i_ahl_lookup_assertions (.clk, .sys_rst, .ce, .reg_rd, .cell_valid,
    .cell_ready_ff, .done_ff, .discard_ff, .misrouted_ff, .evt_mis_cell_ff, .reg_rvalid_ff, .sram_wr_ff,
    .sram_addr_ff, .sram_wdata_ff, .sram_rdata);

// ===== verif/ahl_lookup_test.sv
module ahl_lookup_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_ff;
    logic reg_rvalid_ff, cell_ready_ff, done_ff, discard_ff, misrouted_ff, evt_mis_cell_ff, sram_rd_ff, sram_wr_ff;
    logic cell_valid = 1'b0;
    logic [4:0] cell_port = 5'h00;
    logic [31:0] cell_hdr = 32'h0000_0000;
    logic [20:0] sram_addr_ff;
    logic [31:0] sram_wdata_ff, sram_rdata;
    logic f_mis, f_evt, f_dis;
    logic [20:0] rdq [$];
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    ahl_lookup i_ahl_lookup (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .cell_valid(cell_valid), .cell_port(cell_port), .cell_hdr(cell_hdr), .cell_ready_ff(cell_ready_ff),
        .done_ff(done_ff), .discard_ff(discard_ff), .misrouted_ff(misrouted_ff), .evt_mis_cell_ff(evt_mis_cell_ff),
        .evt_vci_or_ff(), .evt_vpi_or_ff(), .sram_addr_ff(sram_addr_ff), .sram_rd_ff(sram_rd_ff),
        .sram_wr_ff(sram_wr_ff), .sram_wdata_ff(sram_wdata_ff), .sram_rdata(sram_rdata));
    ahl_sram_model i_ahl_sram_model (.clk(clk), .sram_addr_ff(sram_addr_ff), .sram_rd_ff(sram_rd_ff),
        .sram_wr_ff(sram_wr_ff), .sram_wdata_ff(sram_wdata_ff), .sram_rdata(sram_rdata));
    task complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (sram_rd_ff === 1'b1)
            rdq.push_back(sram_addr_ff);
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            complete_run();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(reg_rvalid_ff, 1'b1);
        chk(reg_rdata_ff, exp);
    endtask
    task send(input logic [4:0] p, input logic [31:0] h);
        int n;
        rdq.delete();
        @(negedge clk);
        chk(cell_ready_ff, 1'b1);
        cell_port = p;
        cell_hdr = h;
        cell_valid = 1'b1;
        @(negedge clk);
        cell_valid = 1'b0;
        n = 0;
        while (done_ff !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk(n < 60, 1'b1);
        f_mis = misrouted_ff;
        f_evt = evt_mis_cell_ff;
        f_dis = discard_ff;
    endtask
    task saw(input logic [20:0] a);
        logic hit;
        hit = 1'b0;
        foreach (rdq[i])
            if (rdq[i] === a)
                hit = 1'b1;
        chk(hit, 1'b1);
    endtask
    task t_regs;
        rd(16'h011e, 16'h0000);
        rd(16'h0010, 16'h0000);
        wr(16'h011e, 16'h0001);
        rd(16'h011e, 16'h0001);
    endtask
    task t_count;
        wr(16'h0120, 16'h0070);
        wr(16'h0326, 16'h000d);
        wr(16'h0386, 16'h1000);
        i_ahl_sram_model.mem[32'h8050] = 32'h9000_0000;
        i_ahl_sram_model.mem[32'h8054] = 32'h0000_ffff;
        i_ahl_sram_model.mem[32'h8058] = 32'hffff_ffff;
        i_ahl_sram_model.mem[32'h805c] = 32'h0000_0005;
        send(5'h03, 32'h0050_0400);
        saw(21'h8050);
        chk(i_ahl_sram_model.mem[32'h8058], 32'h0000_0000);
        chk(i_ahl_sram_model.mem[32'h805c], 32'h0000_0006);
        send(5'h03, 32'h0050_0403);
        chk(i_ahl_sram_model.mem[32'h8058], 32'h0000_0001);
        chk(i_ahl_sram_model.mem[32'h805c], 32'h0000_0006);
    endtask
    task t_mis;
        wr(16'h0322, 16'h000d);
        wr(16'h0382, 16'h1000);
        wr(16'h0142, 16'h0002);
        wr(16'h0144, 16'h8000);
        send(5'h01, 32'h0020_0400);
        chk(f_mis & f_dis, 1'b1);
        chk(f_evt, 1'b1);
        rd(16'h0146, 16'h0020);
        rd(16'h0148, 16'h0400);
        rd(16'h0144, 16'h4001);
        send(5'h01, 32'h0030_0400);
        wr(16'h0146, 16'hffff);
        rd(16'h0146, 16'h0020);
    endtask
    task t_oam;
        wr(16'h0324, 16'h000d);
        wr(16'h0384, 16'h1000);
        i_ahl_sram_model.mem[32'h8010] = 32'hb000_0000;
        i_ahl_sram_model.mem[32'h8014] = 32'h0000_ffff;
        send(5'h02, 32'h0010_006c);
        saw(21'h0a00);
        send(5'h02, 32'h0010_0050);
        saw(21'h0850);
        wr(16'h011e, 16'h0003);
        send(5'h05, 32'h0010_0050);
        saw(21'h8010);
        saw(21'h0850);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_regs();
        t_count();
        t_mis();
        t_oam();
        complete_run();
    end
endmodule // ahl_lookup_test

// ===== verif/ahl_sram_model.sv
module ahl_sram_model (
    input logic clk,
    input logic [20:0] sram_addr_ff,
    input logic sram_rd_ff,
    input logic sram_wr_ff,
    input logic [31:0] sram_wdata_ff,
    output logic [31:0] sram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [int];
    initial sram_rdata = 32'h0000_0000;
    // unread cycles toggle so stale data reappears only on every second cycle
    always @(posedge clk)
    begin
        if (sram_wr_ff)
            mem[sram_addr_ff] = sram_wdata_ff;
        if (sram_rd_ff)
            sram_rdata <= mem.exists(sram_addr_ff) ? mem[sram_addr_ff] : 32'h0000_0000;
        else
            sram_rdata <= ~sram_rdata;
    end
endmodule // ahl_sram_model
